// *** design/adc_ctrl.sv ***
// two-channel converter control: divider, stabiliser, power, output stage
// assumes one 10 MHz clock, an Avalon-MM master, samples from same-domain logic
`timescale 1ns/10ps
module adc_ctrl #(
	parameter int unsigned WAKE_LIMIT = 20000, // off cycles counted toward wake time
	parameter int unsigned PIPE_D     = 13
)(
	input  wire logic               i_ref_clk,
	input  wire logic               i_rstn,
	input  wire logic [7:0]         i_avs_address,
	input  wire logic               i_avs_read,
	input  wire logic               i_avs_write,
	input  wire logic [31:0]        i_avs_writedata,
	output logic      [31:0]        o_avs_readdata,
	output logic                    o_avs_waitrequest,
	input  wire logic               i_sync,
	input  wire logic               i_power_down_request,
	input  wire logic               i_output_enable_n,
	input  wire logic               i_clk_freq_change,
	input  wire logic signed [12:0] i_ch_a_sample,
	input  wire logic signed [12:0] i_ch_b_sample,
	output logic                    o_conv_en,
	output logic                    o_conv_clk,
	output logic                    o_stabiliser_locked,
	output logic                    o_stabiliser_bypass,
	output logic                    o_ref_on,
	output logic                    o_bias_on,
	output logic                    o_clk_on,
	output logic                    o_waking,
	output logic      [10:0]        o_data,
	output logic                    o_overrange,
	output logic                    o_data_oe,
	output logic                    o_data_clock_out
);
	// saturate a wide sample to 11 bits and flag overrange
	function automatic logic [11:0] sat(input logic signed [12:0] x);
		if (x > adc_ctrl_pkg::FS_POS) begin
			return {1'b1, adc_ctrl_pkg::CODE_MAX};
		end else if (x < adc_ctrl_pkg::FS_NEG) begin
			return {1'b1, adc_ctrl_pkg::CODE_MIN};
		end else begin
			return {1'b0, x[10:0]};
		end
	endfunction

	// recode a two's complement sample to the selected output coding
	function automatic logic [10:0] recode(input logic [10:0] tc, input logic [1:0] f);
		logic [10:0] ob;
		ob = {~tc[10], tc[9:0]};
		if (f == adc_ctrl_pkg::FMT_TWOS) begin
			return tc;
		end else if (f == adc_ctrl_pkg::FMT_GRAY) begin
			return ob ^ {1'b0, ob[10:1]};
		end else begin
			return ob;
		end
	endfunction

	// pin synchronisers; stage one feeds stage two only
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic       sync_prev_q;
	logic       freq_prev_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			pin_s1_q <= 4'h4;
			pin_s2_q <= 4'h4;
			sync_prev_q <= 1'b0;
			freq_prev_q <= 1'b0;
		end else begin
			pin_s1_q <= {i_clk_freq_change, i_output_enable_n, i_power_down_request, i_sync};
			pin_s2_q <= pin_s1_q;
			sync_prev_q <= pin_s2_q[0];
			freq_prev_q <= pin_s2_q[3];
		end
	end
	wire sync_s   = pin_s2_q[0];
	wire pd_pin   = pin_s2_q[1];
	wire oe_pin_n = pin_s2_q[2];
	wire freq_evt = pin_s2_q[3] & ~freq_prev_q;

	// bus slave: one wait state on every access, then the answer
	logic ack_q;
	wire  req    = i_avs_read | i_avs_write;
	wire  wr     = i_avs_write & ack_q;
	wire  wr_sel = wr && (i_avs_address == adc_ctrl_pkg::REG_CHAN_SEL);
	wire  wr_pwr = wr && (i_avs_address == adc_ctrl_pkg::REG_POWER);
	wire  wr_dcs = wr && (i_avs_address == adc_ctrl_pkg::REG_DCS);
	wire  wr_div = wr && (i_avs_address == adc_ctrl_pkg::REG_CLK_DIV);
	wire  wr_out = wr && (i_avs_address == adc_ctrl_pkg::REG_OUT_MODE);
	wire  wr_syn = wr && (i_avs_address == adc_ctrl_pkg::REG_SYNC);
	wire  wr_nsr = wr && (i_avs_address == adc_ctrl_pkg::REG_NSR);
	assign o_avs_waitrequest = req & ~ack_q;

	// configuration registers
	logic [1:0] chan_sel_q;
	logic [1:0] pwr_mode_q;
	logic       dcs_en_q;
	logic [2:0] div_q;
	logic [1:0] fmt_q [2];
	logic [1:0] outen_q;
	logic       sync_en_q;
	logic       sync_once_q;
	logic       armed_q;
	logic       nsr_q;
	wire        accept = sync_s & ~sync_prev_q & sync_en_q & (~sync_once_q | armed_q);
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			ack_q <= 1'b0;
			chan_sel_q <= adc_ctrl_pkg::CHAN_SEL_RST;
			pwr_mode_q <= adc_ctrl_pkg::PWR_NORMAL;
			dcs_en_q <= adc_ctrl_pkg::DCS_RST;
			div_q <= adc_ctrl_pkg::DIV_RST;
			fmt_q[0] <= adc_ctrl_pkg::FMT_RST;
			fmt_q[1] <= adc_ctrl_pkg::FMT_RST;
			outen_q <= 2'h3;
			sync_en_q <= 1'b0;
			sync_once_q <= 1'b0;
			nsr_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
			if (wr_sel) chan_sel_q <= i_avs_writedata[1:0];
			if (wr_pwr) pwr_mode_q <= i_avs_writedata[1:0];
			if (wr_dcs) dcs_en_q <= i_avs_writedata[0];
			if (wr_div) div_q <= i_avs_writedata[2:0];
			if (wr_nsr) nsr_q <= i_avs_writedata[0];
			if (wr_syn) begin
				sync_en_q <= i_avs_writedata[adc_ctrl_pkg::BIT_SYNC_EN];
				sync_once_q <= i_avs_writedata[adc_ctrl_pkg::BIT_SYNC_ONCE];
			end
			// channel writes go to every channel picked in the select register
			for (int c = 0; c < 2; c++) begin
				if (wr_out && chan_sel_q[c]) begin
					fmt_q[c] <= i_avs_writedata[1:0];
					outen_q[c] <= i_avs_writedata[adc_ctrl_pkg::BIT_OUT_EN];
				end
			end
		end
	end

	// one-shot arm: a write that meets a sync keeps the arm set
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			armed_q <= 1'b0;
		end else if (wr_syn) begin
			armed_q <= 1'b1;
		end else if (accept && sync_once_q) begin
			armed_q <= 1'b0;
		end
	end

	// power state machine; wake time follows the time spent off
	adc_ctrl_pkg::pwr_state_t state_q;
	logic [15:0] off_cnt_q;
	logic [15:0] wake_cnt_q;
	logic        standby_q;
	wire  pd_req      = pd_pin | (pwr_mode_q != adc_ctrl_pkg::PWR_NORMAL);
	wire  standby_sel = ~pd_pin & (pwr_mode_q == adc_ctrl_pkg::PWR_STANDBY);
	wire  [15:0] wake_len = standby_q ? (off_cnt_q >> adc_ctrl_pkg::STANDBY_SHIFT) : off_cnt_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			state_q <= adc_ctrl_pkg::ST_RUN;
			off_cnt_q <= 16'h0000;
			wake_cnt_q <= 16'h0000;
			standby_q <= 1'b0;
		end else begin
			if (pd_req) standby_q <= standby_sel;
			case (state_q)
				adc_ctrl_pkg::ST_RUN: begin
					off_cnt_q <= 16'h0000;
					if (pd_req) state_q <= adc_ctrl_pkg::ST_OFF;
				end
				adc_ctrl_pkg::ST_OFF: begin
					if (off_cnt_q < 16'(WAKE_LIMIT)) off_cnt_q <= off_cnt_q + 16'h0001;
					if (!pd_req) begin
						state_q <= adc_ctrl_pkg::ST_WAKE;
						wake_cnt_q <= wake_len;
					end
				end
				adc_ctrl_pkg::ST_WAKE: begin
					wake_cnt_q <= wake_cnt_q - 16'h0001;
					if (pd_req) begin
						state_q <= adc_ctrl_pkg::ST_OFF;
						off_cnt_q <= 16'h0000;
					end else if (wake_cnt_q <= 16'h0001) begin
						state_q <= adc_ctrl_pkg::ST_RUN;
						standby_q <= 1'b0;
					end
				end
				default: state_q <= adc_ctrl_pkg::ST_RUN;
			endcase
		end
	end
	wire clk_run = (state_q != adc_ctrl_pkg::ST_OFF);
	assign o_clk_on  = clk_run;
	assign o_bias_on = clk_run;
	assign o_ref_on  = clk_run | standby_q;
	assign o_waking  = (state_q == adc_ctrl_pkg::ST_WAKE);

	// stabiliser relock timer; held loaded while the clock is stopped
	logic [4:0] relock_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || freq_evt || !clk_run || (wr_dcs && !dcs_en_q)) begin
			relock_q <= 5'(adc_ctrl_pkg::RELOCK_CYC);
		end else if (relock_q != 5'h00) begin
			relock_q <= relock_q - 5'h01;
		end
	end
	// the loop is modelled at any rate, even below 40 MHz where it need not work
	assign o_stabiliser_locked = dcs_en_q & (relock_q == 5'h00);
	assign o_stabiliser_bypass = dcs_en_q & (relock_q != 5'h00);

	// integer divider; count zero is the initial state and the sampling edge
	logic [2:0] div_cnt_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || !clk_run || accept) begin
			div_cnt_q <= 3'h0;
		end else if (div_cnt_q >= div_q) begin
			div_cnt_q <= 3'h0;
		end else begin
			div_cnt_q <= div_cnt_q + 3'h1;
		end
	end
	assign o_conv_en = clk_run & (div_cnt_q == 3'h0);
	// high time is half the ratio rounded up when locked, else the raw one-cycle pulse
	wire [3:0] hi_len = o_stabiliser_locked ? ({1'b0, div_q} + 4'h2) >> 1 : 4'h1;
	assign o_conv_clk = clk_run & ({1'b0, div_cnt_q} < hi_len);

	// capture and fixed-latency pipeline shared by data and overrange
	logic [23:0] pipe_q [PIPE_D];
	wire  [23:0] cap_word = {sat(i_ch_a_sample), sat(i_ch_b_sample)};
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			for (int i = 0; i < PIPE_D; i++) pipe_q[i] <= 24'h000000;
		end else begin
			if (o_conv_en) pipe_q[0] <= cap_word;
			for (int i = 1; i < PIPE_D; i++) pipe_q[i] <= pipe_q[i - 1];
		end
	end
	wire [23:0] tap = nsr_q ? pipe_q[adc_ctrl_pkg::LAT_NSR - 1]
	                        : pipe_q[adc_ctrl_pkg::LAT_BASE - 1];

	// output stage: a in the high slot, b in the low slot
	wire only_a = (outen_q == 2'b01);
	wire only_b = (outen_q == 2'b10);
	wire use_b  = only_b | (~only_a & o_data_clock_out);
	wire [11:0] pick     = use_b ? tap[11:0] : tap[23:12];
	wire [1:0]  pick_fmt = use_b ? fmt_q[1] : fmt_q[0];
	// drivers off if the pin asks, both channel enables are clear, or the power state is not run (off or waking)
	wire drv_on = (state_q == adc_ctrl_pkg::ST_RUN) & ~oe_pin_n & (|outen_q);
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_data <= 11'h000;
			o_overrange <= 1'b0;
			o_data_oe <= 1'b0;
			o_data_clock_out <= 1'b0;
		end else begin
			o_data <= recode(pick[10:0], pick_fmt);
			o_overrange <= pick[11];
			o_data_oe <= drv_on;
			o_data_clock_out <= clk_run & ~o_data_clock_out;
		end
	end

	// register read decode
	logic [31:0] rd_word;
	wire         rsel = ~chan_sel_q[0];
	always_comb begin
		if (i_avs_address == adc_ctrl_pkg::REG_CHAN_SEL) begin
			rd_word = {30'h0, chan_sel_q};
		end else if (i_avs_address == adc_ctrl_pkg::REG_POWER) begin
			rd_word = {30'h0, pwr_mode_q};
		end else if (i_avs_address == adc_ctrl_pkg::REG_DCS) begin
			rd_word = {31'h0, dcs_en_q};
		end else if (i_avs_address == adc_ctrl_pkg::REG_CLK_DIV) begin
			rd_word = {29'h0, div_q};
		end else if (i_avs_address == adc_ctrl_pkg::REG_OUT_MODE) begin
			rd_word = {27'h0, outen_q[rsel], 2'h0, fmt_q[rsel]};
		end else if (i_avs_address == adc_ctrl_pkg::REG_SYNC) begin
			rd_word = {29'h0, sync_once_q, sync_en_q, 1'b0};
		end else if (i_avs_address == adc_ctrl_pkg::REG_NSR) begin
			rd_word = {31'h0, nsr_q};
		end else if (i_avs_address == adc_ctrl_pkg::REG_STATUS) begin
			rd_word = {26'h0, armed_q, o_data_oe, o_waking, ~clk_run,
			           o_stabiliser_bypass, o_stabiliser_locked};
		end else begin
			rd_word = 32'h0; // unmapped reads as zero
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_avs_readdata <= 32'h0;
		end else if (i_avs_read && !ack_q) begin
			o_avs_readdata <= rd_word;
		end
	end

	// checks; the gap helper counts cycles between undisturbed divider ticks
	logic [3:0] gap_q;
	logic       clean_q;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || o_conv_en) begin
			gap_q <= 4'h1;
		end else if (gap_q != 4'hf) begin
			gap_q <= gap_q + 4'h1;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || accept || !clk_run || wr_div) begin
			clean_q <= 1'b0;
		end else if (o_conv_en) begin
			clean_q <= 1'b1;
		end
	end

	property p_div_gap;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(o_conv_en && clean_q) |-> (gap_q == {1'b0, div_q} + 4'h1);
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("divider period wrong");
	property p_sync_restart;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(accept && clk_run && !pd_req) |=> o_conv_en;
	endproperty
	a_sync_restart: assert property (p_sync_restart) else $error("sync did not restart");
	property p_sync_once;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(accept && sync_once_q && !wr_syn) |=> !armed_q ##1 !accept;
	endproperty
	a_sync_once: assert property (p_sync_once) else $error("one-shot sync rearmed");
	property p_dcs_default;
		@(posedge i_ref_clk) $rose(i_rstn) |-> dcs_en_q;
	endproperty
	a_dcs_default: assert property (p_dcs_default) else $error("stabiliser off at reset");
	sequence s_bypassed;
		o_stabiliser_bypass [*8];
	endsequence
	sequence s_relocked;
		##[1:10] o_stabiliser_locked;
	endsequence
	property p_relock;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(freq_evt && dcs_en_q && clk_run && !pd_req) |=> s_bypassed ##0 s_relocked;
	endproperty
	a_relock: assert property (p_relock) else $error("stabiliser relock timing");
	property p_pd_hiz;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		pd_pin |=> !o_bias_on ##1 !o_data_oe;
	endproperty
	a_pd_hiz: assert property (p_pd_hiz) else $error("drivers on in power-down");
	property p_oe_pin;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		oe_pin_n |=> !o_data_oe;
	endproperty
	a_oe_pin: assert property (p_oe_pin) else $error("enable pin ignored");
	property p_lat_base;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(o_conv_en && !nsr_q) ##1 (!nsr_q) [*8] ##1 (!nsr_q) ##1 (!nsr_q) |-> tap == $past(cap_word, 10);
	endproperty
	a_lat_base: assert property (p_lat_base) else $error("latency not 10");
	property p_lat_nsr;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(o_conv_en && nsr_q) ##1 nsr_q [*8] ##1 nsr_q [*4] ##1 nsr_q |-> tap == $past(cap_word, 13);
	endproperty
	a_lat_nsr: assert property (p_lat_nsr) else $error("latency not 13");
	property p_standby_ref;
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(pd_req && standby_sel) |=> (o_ref_on && !o_clk_on);
	endproperty
	a_standby_ref: assert property (p_standby_ref) else $error("standby lost reference");
endmodule

// *** design/adc_ctrl_pkg.sv ***
// holds the register map, field positions, reset values and timing counts
// assumes a 10 MHz reference clock and word-indexed register addresses
package adc_ctrl_pkg;
	// register indices; the byte address is four times the index
	localparam logic [7:0] REG_CHAN_SEL = 8'h05;
	localparam logic [7:0] REG_POWER    = 8'h08;
	localparam logic [7:0] REG_DCS      = 8'h09;
	localparam logic [7:0] REG_CLK_DIV  = 8'h0b;
	localparam logic [7:0] REG_OUT_MODE = 8'h14;
	localparam logic [7:0] REG_SYNC     = 8'h3a;
	localparam logic [7:0] REG_NSR      = 8'h3c;
	localparam logic [7:0] REG_STATUS   = 8'h40;
	// field positions
	localparam int unsigned BIT_OUT_EN    = 4;
	localparam int unsigned BIT_SYNC_EN   = 1;
	localparam int unsigned BIT_SYNC_ONCE = 2;
	// reset values
	localparam logic [1:0] CHAN_SEL_RST = 2'h3;
	localparam logic [1:0] FMT_RST      = 2'h1;
	localparam logic [2:0] DIV_RST      = 3'h0;
	localparam logic       DCS_RST      = 1'b1;
	// timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned RELOCK_MIN_NS = 1500;
	localparam int unsigned RELOCK_CYC    = (RELOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LAT_BASE      = 10;
	localparam int unsigned LAT_NSR       = 13;
	localparam int unsigned STANDBY_SHIFT = 2;
	// sample coding limits
	localparam logic signed [12:0] FS_POS   = 13'sh03ff;
	localparam logic signed [12:0] FS_NEG   = 13'sh1c00;
	localparam logic [10:0]        CODE_MAX = 11'h3ff;
	localparam logic [10:0]        CODE_MIN = 11'h400;
	typedef enum logic [1:0] {FMT_OFFSET = 2'h0, FMT_TWOS = 2'h1, FMT_GRAY = 2'h2} out_fmt_t;
	typedef enum logic [1:0] {PWR_NORMAL = 2'h0, PWR_DOWN = 2'h1, PWR_STANDBY = 2'h2} pwr_mode_t;
	typedef enum logic [1:0] {ST_RUN = 2'b00, ST_OFF = 2'b01, ST_WAKE = 2'b11} pwr_state_t;
endpackage

// *** tb/capture_model.sv ***
// capture logic model: latches the interleaved samples by data clock slot
// assumes data, data clock and enable are registered on the same rising edge
`timescale 1ns/10ps
module capture_model (
	input  wire logic        i_ref_clk,
	input  wire logic [10:0] i_data,
	input  wire logic        i_dco,
	input  wire logic        i_oe,
	output logic      [10:0] o_slot_a,
	output logic      [10:0] o_slot_b
);
	// the data clock level names the slot; nothing is latched while drivers are off
	always_ff @(posedge i_ref_clk) begin
		if (i_oe && i_dco) begin
			o_slot_a <= i_data;
		end else if (i_oe && !i_dco) begin
			o_slot_b <= i_data;
		end
	end
endmodule

// *** tb/adc_ctrl_tb_top.sv ***
// self-checking bench for the converter control block
// assumes one 10 MHz clock; inputs move by non-blocking assignment on the rising edge
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module adc_ctrl_tb_top;
	logic               i_ref_clk, i_rstn, i_avs_read, i_avs_write, i_sync;
	logic               i_power_down_request, i_output_enable_n, i_clk_freq_change;
	logic        [7:0]  i_avs_address;
	logic        [31:0] i_avs_writedata, o_avs_readdata, q;
	logic signed [12:0] i_ch_a_sample, i_ch_b_sample;
	logic               o_avs_waitrequest, o_conv_en, o_conv_clk, o_stabiliser_locked;
	logic               o_stabiliser_bypass, o_ref_on, o_bias_on, o_clk_on, o_waking;
	logic               o_overrange, o_data_oe, o_data_clock_out;
	logic        [10:0] o_data, slot_a, slot_b;
	int                 n_mismatch = 0;
	int                 checks = 0;
	adc_ctrl #(.WAKE_LIMIT(40)) dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_sync(i_sync),
		.i_power_down_request(i_power_down_request), .i_output_enable_n(i_output_enable_n),
		.i_clk_freq_change(i_clk_freq_change), .i_ch_a_sample(i_ch_a_sample),
		.i_ch_b_sample(i_ch_b_sample), .o_conv_en(o_conv_en), .o_conv_clk(o_conv_clk),
		.o_stabiliser_locked(o_stabiliser_locked), .o_stabiliser_bypass(o_stabiliser_bypass),
		.o_ref_on(o_ref_on), .o_bias_on(o_bias_on), .o_clk_on(o_clk_on), .o_waking(o_waking),
		.o_data(o_data), .o_overrange(o_overrange), .o_data_oe(o_data_oe),
		.o_data_clock_out(o_data_clock_out));
	capture_model cap_u (.i_ref_clk(i_ref_clk), .i_data(o_data), .i_dco(o_data_clock_out),
		.i_oe(o_data_oe), .o_slot_a(slot_a), .o_slot_b(slot_b));
	// values read right after an edge are those the edge sampled
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// one Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		tick(1);
		// no cycle count assumed; only the watchdog ends a wait that never answers
		while (o_avs_waitrequest !== 1'b0) tick(1);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		// one idle edge so a following access never rewrites a strobe in this step
		tick(1);
	endtask
	// expected code: saturate, then twos, offset or gray of offset
	function automatic logic [10:0] enc(input logic [1:0] f, input logic signed [12:0] v);
		logic [10:0] t;
		t = (v > adc_ctrl_pkg::FS_POS) ? 11'h3ff : (v < adc_ctrl_pkg::FS_NEG) ? 11'h400 : v[10:0];
		if (f == 2'h1) return t;
		t = t ^ 11'h400;
		return (f == 2'h0) ? t : t ^ (t >> 1);
	endfunction
	task automatic reset_chk;
		bus(1'b0, adc_ctrl_pkg::REG_DCS, 32'h0);
		`CHK(q[0], 1'b1)
		bus(1'b0, adc_ctrl_pkg::REG_OUT_MODE, 32'h0);
		`CHK(q[4:0], 5'h11)
		bus(1'b1, 8'h7f, 32'hffff_ffff);
		bus(1'b0, 8'h7f, 32'h0);
		`CHK(q, 32'h0)
	endtask
	// frequency change: bypass for the relock span, then locked again
	task automatic relock_chk;
		int n;
		for (n = 0; n < 60 && o_stabiliser_locked !== 1'b1; n++) tick(1);
		i_clk_freq_change <= 1'b1;
		tick(1);
		i_clk_freq_change <= 1'b0;
		for (n = 0; n < 10 && o_stabiliser_bypass !== 1'b1; n++) tick(1);
		`CHK(o_stabiliser_locked, 1'b0)
		for (n = 1; n < 40 && o_stabiliser_bypass === 1'b1; n++) tick(1);
		`CHK(n - 1, adc_ctrl_pkg::RELOCK_CYC)
		`CHK(o_stabiliser_locked, 1'b1)
	endtask
	// every ratio: conversion period and high time of the divided clock
	task automatic div_chk;
		int n;
		int h;
		for (int r = 1; r <= 8; r++) begin
			bus(1'b1, adc_ctrl_pkg::REG_CLK_DIV, r - 1);
			tick(10);
			for (n = 0; n < 20 && o_conv_en !== 1'b1; n++) tick(1);
			n = 0;
			h = 0;
			do begin
				tick(1);
				n++;
				h += (o_conv_clk === 1'b1);
			end while (o_conv_en !== 1'b1 && n < 20);
			`CHK(n, r)
			`CHK(h, (r + 1) / 2)
		end
	endtask
	// sync k cycles after a conversion; delay from pulse to next conversion
	task automatic sync_d(input int k, output int d);
		for (d = 0; d < 20 && o_conv_en !== 1'b1; d++) tick(1);
		tick(k);
		i_sync <= 1'b1;
		tick(1);
		i_sync <= 1'b0;
		for (d = 1; d < 30 && o_conv_en !== 1'b1; d++) tick(1);
		tick(12);
	endtask
	task automatic sync_chk;
		int d1;
		int d2;
		bus(1'b1, adc_ctrl_pkg::REG_CLK_DIV, 32'h7);
		bus(1'b1, adc_ctrl_pkg::REG_SYNC, 32'h2);
		sync_d(0, d1);
		sync_d(1, d2);
		`CHK(d2, d1)
		bus(1'b1, adc_ctrl_pkg::REG_SYNC, 32'h6);
		sync_d(0, d2);
		`CHK(d2, d1)
		sync_d(1, d2);
		`CHK(d2 !== d1, 1'b1)
		bus(1'b1, adc_ctrl_pkg::REG_CLK_DIV, 32'h0);
	endtask
	// all three codings at the full-scale boundaries and beyond
	task automatic code_chk;
		logic signed [12:0] v [5] = '{-13'sd1500, -13'sd1024, 13'sd0, 13'sd1023, 13'sd1500};
		for (int f = 0; f < 3; f++) begin
			bus(1'b1, adc_ctrl_pkg::REG_OUT_MODE, 32'h10 | f);
			foreach (v[i]) begin
				i_ch_a_sample <= v[i];
				i_ch_b_sample <= v[i];
				tick(20);
				`CHK(o_data, enc(f, v[i]))
				`CHK(o_overrange, v[i] > 1023 || v[i] < -1024)
			end
		end
		bus(1'b1, adc_ctrl_pkg::REG_OUT_MODE, 32'h11);
	endtask
	// step into overrange; data and flag must land on the same edge
	task automatic lat(output int n);
		i_ch_a_sample <= 13'sh0;
		i_ch_b_sample <= 13'sh0;
		tick(25);
		i_ch_a_sample <= 13'sd1500;
		i_ch_b_sample <= 13'sd1500;
		for (n = 0; n < 40 && o_data !== 11'h3ff; n++) tick(1);
		`CHK(o_overrange, 1'b1)
	endtask
	task automatic lat_chk;
		int n0;
		int n1;
		lat(n0);
		// set on one edge, captured on the next, then the pipeline, then the output register
		`CHK(n0, adc_ctrl_pkg::LAT_BASE + 2)
		bus(1'b1, adc_ctrl_pkg::REG_NSR, 32'h1);
		lat(n1);
		`CHK(n1 - n0, adc_ctrl_pkg::LAT_NSR - adc_ctrl_pkg::LAT_BASE)
		bus(1'b1, adc_ctrl_pkg::REG_NSR, 32'h0);
	endtask
	// slot contents with both and one channel enabled; drivers off with no channel enabled
	task automatic chan_chk;
		logic x;
		i_ch_a_sample <= 13'sd5;
		i_ch_b_sample <= -13'sd3;
		tick(20);
		`CHK(slot_a, 11'h005)
		`CHK(slot_b, 11'h7fd)
		x = o_data_clock_out;
		tick(1);
		`CHK(o_data_clock_out, ~x)
		bus(1'b1, adc_ctrl_pkg::REG_CHAN_SEL, 32'h1);
		bus(1'b1, adc_ctrl_pkg::REG_OUT_MODE, 32'h01);
		bus(1'b1, adc_ctrl_pkg::REG_CHAN_SEL, 32'h3);
		tick(20);
		`CHK(slot_a, 11'h7fd)
		`CHK(slot_b, 11'h7fd)
		bus(1'b1, adc_ctrl_pkg::REG_OUT_MODE, 32'h01);
		tick(5);
		`CHK(o_data_oe, 1'b0)
		bus(1'b1, adc_ctrl_pkg::REG_OUT_MODE, 32'h11);
		i_output_enable_n <= 1'b1;
		tick(6);
		`CHK(o_data_oe, 1'b0)
		i_output_enable_n <= 1'b0;
		tick(6);
		`CHK(o_data_oe, 1'b1)
	endtask
	// power-down by pin (m 0) or register mode m, then measure wake-up
	task automatic pwr(input logic [1:0] m, input int off, output int w);
		if (m == 2'h0) i_power_down_request <= 1'b1;
		else bus(1'b1, adc_ctrl_pkg::REG_POWER, {30'h0, m});
		for (w = 0; w < 20 && o_clk_on !== 1'b0; w++) tick(1);
		`CHK(o_ref_on, m == 2'h2)
		`CHK(o_bias_on, 1'b0)
		tick(3);
		`CHK(o_data_oe, 1'b0)
		tick(off);
		if (m == 2'h0) i_power_down_request <= 1'b0;
		else bus(1'b1, adc_ctrl_pkg::REG_POWER, 32'h0);
		for (w = 0; w < 10 && o_waking !== 1'b1; w++) tick(1);
		for (w = 0; w < 100 && o_waking === 1'b1; w++) tick(1);
		tick(10);
		`CHK(o_data_oe, 1'b1)
	endtask
	task automatic pwr_chk;
		int w10;
		int w30;
		int ws;
		int wr;
		pwr(2'h0, 10, w10);
		pwr(2'h0, 30, w30);
		pwr(2'h2, 30, ws);
		pwr(2'h1, 10, wr);
		`CHK(w10 < w30, 1'b1)
		`CHK(ws < w30, 1'b1)
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// 100 ns clock
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	// watchdog: far beyond the roughly one thousand cycles the scenarios need
	initial begin
		tick(20000);
		n_mismatch++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{i_rstn, i_avs_read, i_avs_write, i_sync, i_power_down_request} = 5'h0;
		{i_output_enable_n, i_clk_freq_change, i_avs_address, i_avs_writedata} = '0;
		i_ch_a_sample = 13'sh0;
		i_ch_b_sample = 13'sh0;
		tick(2);
		i_rstn <= 1'b1;
		tick(1);
		reset_chk();
		relock_chk();
		div_chk();
		sync_chk();
		code_chk();
		lat_chk();
		chan_chk();
		pwr_chk();
		tally_and_finish();
	end
endmodule
